/* File: design/rci_pkg.sv */
// Purpose: shared constants and types for the remap command sequencer
// Assumes: 20 MHz clock, plain strobe register port, 32-bit words
// Notes: offsets are byte addresses of aligned words
package rci_pkg;
   // register offsets
   localparam logic [7:0] OFF_CAP = 8'h00; // capability, read only
   localparam logic [7:0] OFF_GCMD = 8'h04; // global command
   localparam logic [7:0] OFF_CCMD = 8'h08; // context-cache command
   localparam logic [7:0] OFF_TLB = 8'h0c; // iotlb command
   localparam logic [7:0] OFF_PMEN = 8'h10; // protected memory enable
   localparam logic [7:0] OFF_STAT = 8'h14; // status
   localparam logic [7:0] OFF_ROOT = 8'h18; // root table pointer
   localparam logic [7:0] OFF_IRTP = 8'h1c; // interrupt table pointer
   localparam logic [7:0] OFF_DTAG = 8'h20; // domain tag check
   // command register field positions
   localparam int B_GO = 0; // start command
   localparam int B_GLOBAL = 1; // global scope
   localparam int B_HINT = 2; // nonleaf_keep_hint on page-selective
   localparam int B_GC_SRTP = 1; // gcmd: set root pointer
   localparam int B_GC_SIRTP = 2; // gcmd: set interrupt pointer
   localparam int B_GC_DMAEN = 3; // gcmd: dma remap enable
   localparam int B_GC_IREN = 4; // gcmd: interrupt remap enable
   localparam int B_GC_WBF = 5; // gcmd: write buffer flush
   localparam int B_GC_IEC = 6; // gcmd: global interrupt entry cache inval
   // capability bits
   localparam int B_CAP_WBF = 0; // write_buffer_flush_required
   localparam int B_CAP_CM = 1; // caching_mode
   // reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic WBF_REQ_DEFAULT = 1'b1;
   localparam logic CM_DEFAULT = 1'b0;
   // timing: each cache operation takes a fixed drain time
   localparam int OP_TIME_NS = 200;
   localparam int CLK_NS = 50;
   localparam int OP_CYCLES = (OP_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] OP_COUNT = 4'(OP_CYCLES);
   // kinds of queued operation
   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_WBF = 3'b001,
      OP_CTX = 3'b010,
      OP_TLB = 3'b011,
      OP_IEC = 3'b100,
      OP_PTR = 3'b101
   } rci_op_t;
   // request to the timing engine
   typedef struct packed {
      logic start;
      rci_op_t op;
   } rci_req_t;
endpackage

/* File: design/rci_timer.sv */
// Purpose: one cache operation timer, counts drain cycles then pulses done
// Assumes: start only while idle
// Notes: reused by the sequencer for flush and invalidation steps
`timescale 1ns/1ps
module rci_timer (
   input wire logic clk,
   input wire logic reset,
   input wire logic start,
   output logic busy,
   output logic done
);
   logic [3:0] cnt_reg, cnt_next; // cycles left
   logic done_reg, done_next; // completion pulse

   // next state of the counter
   always_comb begin
      cnt_next = cnt_reg;
      done_next = 1'b0;
      if (start && cnt_reg == 4'h0) begin
         cnt_next = rci_pkg::OP_COUNT;
      end else if (cnt_reg != 4'h0) begin
         cnt_next = cnt_reg - 4'h1;
         done_next = (cnt_reg == 4'h1);
      end
   end

   // registers only
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_reg <= 4'h0;
         done_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         done_reg <= done_next;
      end
   end

   assign busy = (cnt_reg != 4'h0);
   assign done = done_reg;
endmodule // rci_timer

/* File: design/rci_unit.sv */
// Purpose: command sequencer of one remapping unit with its cache controls
// Assumes: one clock, strobe register port, software keeps its own ordering
// Notes: each unit is independent, nothing here waits on another unit
`timescale 1ns/1ps
module rci_unit (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic dma_remap_on,
   output logic irq_remap_on,
   output logic ctx_cache_valid,
   output logic tlb_cache_valid,
   output logic nonleaf_cache_valid,
   output logic iec_valid,
   output logic [31:0] root_ptr_active,
   output logic [31:0] irq_ptr_active
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FLUSH = 2'b01,
      ST_RUN = 2'b10
   } rci_state_t;

   rci_state_t state_reg, state_next; // sequencer state
   rci_pkg::rci_op_t op_reg, op_next; // operation being carried out
   logic [3:0] src_reg, src_next; // busy flag per command register
   logic hint_reg, hint_next; // page-selective keep-nonleaf request
   logic [31:0] root_reg, root_next; // software root pointer staging
   logic [31:0] irtp_reg, irtp_next; // software interrupt pointer staging
   logic [31:0] root_act_reg, root_act_next; // pointer hardware walks
   logic [31:0] irtp_act_reg, irtp_act_next; // interrupt pointer in use
   logic dma_reg, dma_next;
   logic ir_reg, ir_next;
   logic ctx_reg, ctx_next; // context cache holds entries
   logic tlb_reg, tlb_next; // iotlb holds leaf entries
   logic nl_reg, nl_next; // nonleaf cache holds entries
   logic iec_reg, iec_next; // interrupt entry cache holds entries
   logic [15:0] dtag_reg, dtag_next; // last domain tag offered
   logic dtag_bad_reg, dtag_bad_next; // reserved tag seen under cm
   logic [31:0] rdata_reg, rdata_next;
   logic t_start, t_done; // timer busy is not needed, done alone paces the steps

   // straps: wbf requirement and caching mode are fixed capability bits
   localparam logic CAP_WBF = rci_pkg::WBF_REQ_DEFAULT;
   localparam logic CAP_CM = rci_pkg::CM_DEFAULT;

   // one timer serves flush and invalidation steps in turn
   rci_timer u_timer (
      .clk(clk),
      .reset(reset),
      .start(t_start),
      .busy(),
      .done(t_done)
   );

   // sequencer and register next values
   always_comb begin
      state_next = state_reg;
      op_next = op_reg;
      src_next = src_reg;
      hint_next = hint_reg;
      root_next = root_reg;
      irtp_next = irtp_reg;
      root_act_next = root_act_reg;
      irtp_act_next = irtp_act_reg;
      dma_next = dma_reg;
      ir_next = ir_reg;
      ctx_next = ctx_reg;
      tlb_next = tlb_reg;
      nl_next = nl_reg;
      iec_next = iec_reg;
      dtag_next = dtag_reg;
      dtag_bad_next = dtag_bad_reg;
      rdata_next = rci_pkg::RST_WORD;
      t_start = 1'b0;
      // caches refill while remapping runs; absent entries are never cached
      if (dma_reg) begin
         ctx_next = 1'b1;
         tlb_next = 1'b1;
         nl_next = 1'b1;
      end
      if (ir_reg) begin
         iec_next = 1'b1;
      end
      // register writes, ignored while a command is pending
      if (wr && state_reg == ST_IDLE) begin
         unique case (addr)
            rci_pkg::OFF_ROOT: root_next = wdata;
            rci_pkg::OFF_IRTP: irtp_next = wdata;
            rci_pkg::OFF_DTAG: begin
               dtag_next = wdata[15:0];
               // tag zero is reserved when caching mode is set
               if (CAP_CM && wdata[15:0] == 16'h0000) begin
                  dtag_bad_next = 1'b1;
               end
            end
            rci_pkg::OFF_GCMD: begin
               dma_next = wdata[rci_pkg::B_GC_DMAEN];
               ir_next = wdata[rci_pkg::B_GC_IREN];
               if (wdata[rci_pkg::B_GC_SRTP] || wdata[rci_pkg::B_GC_SIRTP]) begin
                  op_next = rci_pkg::OP_PTR;
                  src_next = 4'h1;
                  state_next = ST_RUN;
                  t_start = 1'b1;
               end else if (wdata[rci_pkg::B_GC_IEC]) begin
                  op_next = rci_pkg::OP_IEC;
                  src_next = 4'h1;
                  state_next = CAP_WBF ? ST_FLUSH : ST_RUN;
                  t_start = 1'b1;
               end else if (wdata[rci_pkg::B_GC_WBF]) begin
                  op_next = rci_pkg::OP_WBF;
                  src_next = 4'h1;
                  state_next = ST_RUN;
                  t_start = 1'b1;
               end
               // pointer select latches which pointer to swap
               hint_next = wdata[rci_pkg::B_GC_SIRTP];
            end
            rci_pkg::OFF_CCMD: begin
               if (wdata[rci_pkg::B_GO]) begin
                  op_next = rci_pkg::OP_CTX;
                  src_next = 4'h2;
                  state_next = CAP_WBF ? ST_FLUSH : ST_RUN;
                  t_start = 1'b1;
               end
            end
            rci_pkg::OFF_TLB: begin
               if (wdata[rci_pkg::B_GO]) begin
                  op_next = rci_pkg::OP_TLB;
                  src_next = 4'h4;
                  // hint honoured only on page-selective requests
                  hint_next = wdata[rci_pkg::B_HINT] && !wdata[rci_pkg::B_GLOBAL];
                  state_next = CAP_WBF ? ST_FLUSH : ST_RUN;
                  t_start = 1'b1;
               end
            end
            rci_pkg::OFF_PMEN: begin
               if (wdata[rci_pkg::B_GO]) begin
                  op_next = rci_pkg::OP_WBF;
                  src_next = 4'h8;
                  state_next = ST_RUN;
                  t_start = 1'b1;
               end
            end
            default: ; // unmapped or read-only: write dropped
         endcase
      end
      // operation steps
      unique case (state_reg)
         ST_IDLE: ;
         ST_FLUSH: begin
            // implicit write-buffer drain precedes the invalidation
            if (t_done) begin
               state_next = ST_RUN;
               t_start = 1'b1;
            end
         end
         ST_RUN: begin
            if (t_done) begin
               state_next = ST_IDLE;
               src_next = 4'h0;
               unique case (op_reg)
                  rci_pkg::OP_CTX: ctx_next = 1'b0;
                  rci_pkg::OP_TLB: begin
                     // leaf entries only leave the iotlb on an invalidation
                     tlb_next = 1'b0;
                     // keep nonleaf cache when the hint asked for it
                     if (!hint_reg) begin
                        nl_next = 1'b0;
                     end
                  end
                  rci_pkg::OP_IEC: iec_next = 1'b0;
                  rci_pkg::OP_PTR: begin
                     // old tables stay reachable via caches until invalidated
                     if (hint_reg) begin
                        irtp_act_next = irtp_reg;
                     end else begin
                        root_act_next = root_reg;
                     end
                  end
                  default: ;
               endcase
            end
         end
         default: state_next = ST_IDLE;
      endcase
      // read path, data stands the cycle after the strobe
      if (rd) begin
         unique case (addr)
            rci_pkg::OFF_CAP: begin
               rdata_next[rci_pkg::B_CAP_WBF] = CAP_WBF;
               rdata_next[rci_pkg::B_CAP_CM] = CAP_CM;
            end
            rci_pkg::OFF_GCMD: begin
               rdata_next[rci_pkg::B_GC_DMAEN] = dma_reg;
               rdata_next[rci_pkg::B_GC_IREN] = ir_reg;
            end
            rci_pkg::OFF_STAT: begin
               rdata_next[3:0] = src_reg;
               rdata_next[4] = ctx_reg;
               rdata_next[5] = tlb_reg;
               rdata_next[6] = nl_reg;
               rdata_next[7] = iec_reg;
               rdata_next[8] = dtag_bad_reg;
            end
            rci_pkg::OFF_ROOT: rdata_next = root_reg;
            rci_pkg::OFF_IRTP: rdata_next = irtp_reg;
            rci_pkg::OFF_DTAG: rdata_next[15:0] = dtag_reg;
            default: rdata_next = rci_pkg::RST_WORD;
         endcase
      end
   end

   // registers only; this unit shares no state with others
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg <= ST_IDLE;
         op_reg <= rci_pkg::OP_NONE;
         src_reg <= 4'h0;
         hint_reg <= 1'b0;
         root_reg <= rci_pkg::RST_WORD;
         irtp_reg <= rci_pkg::RST_WORD;
         root_act_reg <= rci_pkg::RST_WORD;
         irtp_act_reg <= rci_pkg::RST_WORD;
         dma_reg <= 1'b0;
         ir_reg <= 1'b0;
         ctx_reg <= 1'b0;
         tlb_reg <= 1'b0;
         nl_reg <= 1'b0;
         iec_reg <= 1'b0;
         dtag_reg <= 16'h0000;
         dtag_bad_reg <= 1'b0;
         rdata_reg <= rci_pkg::RST_WORD;
      end else begin
         state_reg <= state_next;
         op_reg <= op_next;
         src_reg <= src_next;
         hint_reg <= hint_next;
         root_reg <= root_next;
         irtp_reg <= irtp_next;
         root_act_reg <= root_act_next;
         irtp_act_reg <= irtp_act_next;
         dma_reg <= dma_next;
         ir_reg <= ir_next;
         ctx_reg <= ctx_next;
         tlb_reg <= tlb_next;
         nl_reg <= nl_next;
         iec_reg <= iec_next;
         dtag_reg <= dtag_next;
         dtag_bad_reg <= dtag_bad_next;
         rdata_reg <= rdata_next;
      end
   end

   // outputs straight from flip-flops
   assign rdata = rdata_reg;
   assign dma_remap_on = dma_reg;
   assign irq_remap_on = ir_reg;
   assign ctx_cache_valid = ctx_reg;
   assign tlb_cache_valid = tlb_reg;
   assign nonleaf_cache_valid = nl_reg;
   assign iec_valid = iec_reg;
   assign root_ptr_active = root_act_reg;
   assign irq_ptr_active = irtp_act_reg;
endmodule // rci_unit

/* File: tb/rci_unit_properties.sv */
// Purpose: port-level checks on the remap command sequencer
// Assumes: bench sends one command at a time and polls status
// Notes: bound into rci_unit at the foot of this file
`timescale 1ns/1ps
module rci_unit_props (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic dma_remap_on,
   input wire logic irq_remap_on,
   input wire logic ctx_cache_valid,
   input wire logic tlb_cache_valid,
   input wire logic nonleaf_cache_valid,
   input wire logic iec_valid,
   input wire logic [31:0] root_ptr_active,
   input wire logic [31:0] irq_ptr_active
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // decoded strobes, plain nets so $past sees one signal
   logic dma_w; // gcmd write asking for dma remap
   logic hint_w; // page-selective iotlb with hint
   logic cap_r; // capability read
   assign dma_w = wr && addr == rci_pkg::OFF_GCMD && wdata[rci_pkg::B_GC_DMAEN];
   assign hint_w = wr && addr == rci_pkg::OFF_TLB && wdata[0] && !wdata[1] && wdata[2];
   assign cap_r = rd && addr == rci_pkg::OFF_CAP;
   // cache kept through the implicit flush, then emptied
   sequence kept_then_cleared(v);
      v[*8] ##[1:4] !v;
   endsequence
   rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
      else $error("read data not zero outside read slot");
   cap_read_a: assert property (cap_r |=> rdata[0] == rci_pkg::WBF_REQ_DEFAULT)
      else $error("capability flush bit wrong");
   dma_cause_a: assert property ($rose(dma_remap_on) |-> $past(dma_w))
      else $error("dma remap enabled without command");
   ctx_refill_a: assert property ($rose(ctx_cache_valid) |-> dma_remap_on || $past(dma_remap_on))
      else $error("context cache filled while remap off");
   ctx_flush_a: assert property (wr && addr == rci_pkg::OFF_CCMD && wdata[0] && ctx_cache_valid
      |=> kept_then_cleared(ctx_cache_valid))
      else $error("context invalidation timing wrong");
   tlb_flush_a: assert property (wr && addr == rci_pkg::OFF_TLB && wdata[0] && tlb_cache_valid
      |=> kept_then_cleared(tlb_cache_valid))
      else $error("iotlb invalidation timing wrong");
   hint_keep_a: assert property (hint_w && nonleaf_cache_valid
      |=> nonleaf_cache_valid[*8] ##1 nonleaf_cache_valid[*4])
      else $error("nonleaf cache dropped despite hint");
   iec_flush_a: assert property (wr && addr == rci_pkg::OFF_GCMD && wdata[rci_pkg::B_GC_IEC]
      && iec_valid |=> kept_then_cleared(iec_valid))
      else $error("interrupt entry invalidation timing wrong");
endmodule // rci_unit_props
bind rci_unit rci_unit_props chk_u (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .dma_remap_on(dma_remap_on), .irq_remap_on(irq_remap_on),
   .ctx_cache_valid(ctx_cache_valid), .tlb_cache_valid(tlb_cache_valid),
   .nonleaf_cache_valid(nonleaf_cache_valid), .iec_valid(iec_valid),
   .root_ptr_active(root_ptr_active), .irq_ptr_active(irq_ptr_active));

/* File: tb/tb_top.sv */
// Purpose: self-checking bench for the remap command sequencer
// Assumes: register port as in the package, one command at a time
// Notes: random pointers from a fixed seed, corner cases by hand
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata, root_ptr_active, irq_ptr_active, got, val;
   logic dma_remap_on, irq_remap_on;
   logic [3:0] cv; // iec, nonleaf, tlb, ctx valids
   int err_count = 0;
   int compares = 0;
   int cyc = 0;
   int seed = 72;
   int n;
   int nl_drops = 0; // negedges at which the nonleaf cache was seen empty
   int k0; // nl_drops before a command
   logic [31:0] modes [3] = '{32'h0000_0003, 32'h0000_0001, 32'h0000_0005};
   always #25 clk = ~clk;
   rci_unit dut_u (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .dma_remap_on(dma_remap_on), .irq_remap_on(irq_remap_on),
      .ctx_cache_valid(cv[0]), .tlb_cache_valid(cv[1]), .nonleaf_cache_valid(cv[2]),
      .iec_valid(cv[3]), .root_ptr_active(root_ptr_active), .irq_ptr_active(irq_ptr_active));
   // count empty nonleaf samples, a hinted invalidation must add none
   always @(negedge clk) begin
      if (cv[2] === 1'b0) nl_drops <= nl_drops + 1;
   end
   // hang guard, well above the few hundred cycles needed
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         end_of_test();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // busy span seen by the status poll: one op time, doubled by an implicit flush
   function automatic int op_span(input bit flushed);
      return (int'(rci_pkg::OP_COUNT) + 1) * (flushed ? 2 : 1);
   endfunction
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rreg(input logic [7:0] a, output logic [31:0] q);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      q = rdata;
   endtask
   // poll status until every busy bit is clear, returns cycles spent
   task automatic cmd(input logic [7:0] a, input logic [31:0] d, output int c);
      int t0;
      wreg(a, d);
      t0 = cyc;
      got = 32'hffff_ffff;
      for (int i = 0; i < 40 && got[3:0] !== 4'h0; i++) rreg(rci_pkg::OFF_STAT, got);
      check(32'(got[3:0]), 32'h0);
      c = cyc - t0;
   endtask
   task automatic wait_cv(input int i);
      for (int k = 0; k < 30 && cv[i] !== 1'b1; k++) @(posedge clk);
   endtask
   task automatic end_of_test();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      check(32'({dma_remap_on, irq_remap_on, cv}), 32'h0);
      rreg(rci_pkg::OFF_CAP, got);
      check(32'(got[1:0]), 32'({rci_pkg::CM_DEFAULT, rci_pkg::WBF_REQ_DEFAULT}));
      // unmapped places read zero and ignore writes
      repeat (6) begin
         val = $random(seed);
         wreg({2'b11, val[5:0]}, val);
         rreg({2'b11, val[5:0]}, got);
         check(got, 32'h0);
      end
      val = $random(seed);
      wreg(rci_pkg::OFF_ROOT, val);
      cmd(rci_pkg::OFF_GCMD, 32'h0000_0002, n);
      check(root_ptr_active, val);
      cmd(rci_pkg::OFF_GCMD, 32'h0000_0008, n);
      check(32'(dma_remap_on), 32'h1);
      wait_cv(0);
      // pending context command drops the gcmd and root writes
      wreg(rci_pkg::OFF_CCMD, 32'h0000_0001);
      rreg(rci_pkg::OFF_STAT, got);
      check(32'(got[3:0]), 32'h2);
      wreg(rci_pkg::OFF_GCMD, 32'h0000_0000);
      wreg(rci_pkg::OFF_ROOT, ~val);
      cmd(rci_pkg::OFF_STAT, 32'h0000_0000, n);
      check(32'(dma_remap_on), 32'h1);
      cmd(rci_pkg::OFF_GCMD, 32'h0000_000a, n);
      check(root_ptr_active, val);
      // every iotlb mode: global, page, page with hint
      for (int m = 0; m < 3; m++) begin
         wait_cv(1);
         wait_cv(2);
         k0 = nl_drops;
         cmd(rci_pkg::OFF_TLB, modes[m], n);
         check(32'(n > op_span(1'b1)), 32'h1);
         check(32'(nl_drops - k0), 32'(!modes[m][2]));
      end
      val = $random(seed);
      wreg(rci_pkg::OFF_IRTP, val);
      cmd(rci_pkg::OFF_GCMD, 32'h0000_000c, n);
      check(irq_ptr_active, val);
      cmd(rci_pkg::OFF_GCMD, 32'h0000_0048, n);
      cmd(rci_pkg::OFF_GCMD, 32'h0000_0018, n);
      check(32'(irq_remap_on), 32'h1);
      wait_cv(3);
      cmd(rci_pkg::OFF_GCMD, 32'h0000_0058, n);
      check(32'(n > op_span(1'b1)), 32'h1);
      cmd(rci_pkg::OFF_PMEN, 32'h0000_0001, n);
      check(32'(n > op_span(1'b0) && n <= op_span(1'b1)), 32'h1);
      // explicit flush after an uncached update, no flush in front of it
      cmd(rci_pkg::OFF_GCMD, 32'h0000_0038, n);
      check(32'(n > op_span(1'b0) && n <= op_span(1'b1)), 32'h1);
      // random root switches, each followed by context then iotlb
      repeat (6) begin
         val = $random(seed);
         wreg(rci_pkg::OFF_ROOT, val);
         cmd(rci_pkg::OFF_GCMD, 32'h0000_001a, n);
         check(root_ptr_active, val);
         cmd(rci_pkg::OFF_CCMD, 32'h0000_0001, n);
         cmd(rci_pkg::OFF_TLB, 32'h0000_0003, n);
      end
      // domain tag store reads back; zero is only flagged under caching mode
      val = $random(seed);
      wreg(rci_pkg::OFF_DTAG, val);
      rreg(rci_pkg::OFF_DTAG, got);
      check(got, 32'(val[15:0]));
      wreg(rci_pkg::OFF_DTAG, 32'h0000_0000);
      rreg(rci_pkg::OFF_STAT, got);
      check(32'(got[8]), 32'(rci_pkg::CM_DEFAULT));
      // second reset in mid-run clears everything
      @(posedge clk);
      reset <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      check(32'({dma_remap_on, irq_remap_on, cv}), 32'h0);
      check(root_ptr_active | irq_ptr_active, 32'h0);
      reset <= 1'b0;
      end_of_test();
   end
endmodule // tb_top
